// ---- hw/scg_sleep_gate.sv ----
`timescale 1ns/1ps
module scg_sleep_gate
  import scg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // power mode requests from the power controller
  input  wire logic              sleep_req,
  input  wire logic              deepsleep_req,
  // companion settings for run and deep sleep
  input  wire scg_gate_t         run_gate,
  input  wire scg_gate_t         deepsleep_gate,
  // unit side
  input  wire scg_gate_t         unit_access,
  output scg_gate_t              unit_clk_en,
  output scg_gate_t              unit_fault,
  output scg_mode_t              mode,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  // assert at once, release on an edge so no flop leaves reset mid-cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic rst_sync_n = rst_s2_q;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scg_gate_t   sleep_gate_q;
  logic        auto_gate_sel_q;
  scg_gate_t   irq_stat_q;
  scg_gate_t   irq_en_q;
  scg_mode_t   mode_q;
  scg_gate_t   clk_en_q;
  scg_gate_t   fault_q;
  logic        irq_q;

  logic              awready_q;
  logic              wready_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  // ----------------------------------------------------------------
  // write channel decode
  // ----------------------------------------------------------------
  wire logic aw_hs   = awvalid && awready_q;
  wire logic w_hs    = wvalid && wready_q;
  wire logic b_hs    = bvalid_q && bready;
  // both halves held and no response pending: commit this cycle
  wire logic wr_go   = aw_got_q && w_got_q && !bvalid_q;

  wire logic wr_gate   = wr_go && (aw_addr_q == SLEEP_GATE_OFF);
  wire logic wr_cfg    = wr_go && (aw_addr_q == CFG_OFF);
  wire logic wr_active = wr_go && (aw_addr_q == ACTIVE_OFF);
  wire logic wr_stat   = wr_go && (aw_addr_q == IRQ_STAT_OFF);
  wire logic wr_clr    = wr_go && (aw_addr_q == IRQ_CLR_OFF);
  wire logic wr_en     = wr_go && (aw_addr_q == IRQ_EN_OFF);
  wire logic wr_mapped = wr_gate || wr_cfg || wr_active || wr_stat || wr_clr || wr_en;

  // only the two gating bits take data; reserved positions ignore it
  wire logic strb_hi = w_strb_q[BUS_CTRL0_BIT/8];
  wire logic strb_lo = w_strb_q[WATCHDOG_BIT/8];

  // ----------------------------------------------------------------
  // register write enables
  // ----------------------------------------------------------------
  // the low lane carries every bit of the config, enable and clear registers, so it alone gates them
  wire logic      auto_sel_we = wr_cfg && w_strb_q[0];
  wire logic      irq_en_we   = wr_en && w_strb_q[0];
  wire logic      irq_clr_we  = wr_clr && w_strb_q[0];
  wire scg_gate_t irq_en_d    = irq_en_we ? scg_gate_t'(w_data_q[1:0]) : irq_en_q;

  // ----------------------------------------------------------------
  // read channel decode
  // ----------------------------------------------------------------
  wire logic ar_hs = arvalid && arready_q;
  wire logic r_hs  = rvalid_q && rready;

  logic [DATA_W-1:0] gate_rd;
  always_comb begin
    gate_rd = SLEEP_GATE_FIXED;
    gate_rd[BUS_CTRL0_BIT] = sleep_gate_q.bus_ctrl0;
    gate_rd[WATCHDOG_BIT]  = sleep_gate_q.watchdog;
  end

  // araddr is decoded live and captured only at the handshake edge
  wire logic rd_gate   = (araddr == SLEEP_GATE_OFF);
  wire logic rd_cfg    = (araddr == CFG_OFF);
  wire logic rd_active = (araddr == ACTIVE_OFF);
  wire logic rd_stat   = (araddr == IRQ_STAT_OFF);
  wire logic rd_clr    = (araddr == IRQ_CLR_OFF);
  wire logic rd_en     = (araddr == IRQ_EN_OFF);
  wire logic rd_mapped = rd_gate || rd_cfg || rd_active || rd_stat || rd_clr || rd_en;

  // the clear register is write-only and reads as zero
  wire logic [DATA_W-1:0] rd_word =
      rd_gate   ? gate_rd :
      rd_cfg    ? {{(DATA_W-1){1'b0}}, auto_gate_sel_q} :
      rd_active ? {{(DATA_W-4){1'b0}}, mode_q, clk_en_q} :
      rd_stat   ? {{(DATA_W-2){1'b0}}, irq_stat_q} :
      rd_en     ? {{(DATA_W-2){1'b0}}, irq_en_q} :
                  {DATA_W{1'b0}};

  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      awready_q <= 1'b1;
      aw_got_q  <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_hs) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_got_q  <= 1'b0;
    end else if (b_hs) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wready_q <= 1'b1;
      w_got_q  <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (w_hs) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_got_q  <= 1'b0;
    end else if (b_hs) begin
      wready_q <= 1'b1;
    end
  end

  // writes to read-only registers are accepted and dropped
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // reserved bits have no flop; their read value is the fixed pattern
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sleep_gate_q <= GATE_RESET;
    end else if (wr_gate) begin
      if (strb_hi) begin
        sleep_gate_q.bus_ctrl0 <= w_data_q[BUS_CTRL0_BIT];
      end
      if (strb_lo) begin
        sleep_gate_q.watchdog <= w_data_q[WATCHDOG_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auto_gate_sel_q <= 1'b0;
    end else if (auto_sel_we) begin
      auto_gate_sel_q <= w_data_q[AUTO_GATE_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_en_q <= GATE_RESET;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // ----------------------------------------------------------------
  // power mode and gating
  // ----------------------------------------------------------------
  // without automatic gating the run settings hold even while asleep
  scg_mode_t mode_d;
  always_comb begin
    if (!auto_gate_sel_q) begin
      mode_d = MODE_RUN;
    end else if (deepsleep_req) begin
      mode_d = MODE_DEEP;
    end else if (sleep_req) begin
      mode_d = MODE_SLEEP;
    end else begin
      mode_d = MODE_RUN;
    end
  end

  scg_gate_t clk_en_d;
  always_comb begin
    unique case (mode_q)
      MODE_RUN:   clk_en_d = run_gate;
      MODE_SLEEP: clk_en_d = sleep_gate_q;
      MODE_DEEP:  clk_en_d = deepsleep_gate;
      default:    clk_en_d = GATE_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // enables follow the mode a cycle later, so a unit sees one clean change
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_en_q <= GATE_RESET;
    end else begin
      clk_en_q <= clk_en_d;
    end
  end

  // ----------------------------------------------------------------
  // unit access faults and interrupt
  // ----------------------------------------------------------------
  // judged against the enable the unit actually sees this cycle
  wire scg_gate_t fault_d  = unit_access & ~clk_en_q;
  wire scg_gate_t clr_bits = irq_clr_we ? scg_gate_t'(w_data_q[1:0]) : GATE_RESET;
  // a fault in the clearing cycle survives the clear
  wire scg_gate_t stat_d   = (irq_stat_q & ~clr_bits) | fault_d;
  // the new enable counts at once, so irq never lags an enable write
  wire logic      irq_d    = |(stat_d & irq_en_d);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_q <= GATE_RESET;
    end else begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_q <= GATE_RESET;
    end else begin
      irq_stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every port is a flop output, so no decode path reaches a pin
  assign awready     = awready_q;
  assign wready      = wready_q;
  assign bvalid      = bvalid_q;
  assign bresp       = bresp_q;
  assign arready     = arready_q;
  assign rvalid      = rvalid_q;
  assign rdata       = rdata_q;
  assign rresp       = rresp_q;
  assign unit_clk_en = clk_en_q;
  assign unit_fault  = fault_q;
  assign mode        = mode_q;
  assign irq         = irq_q;

endmodule

// ---- hw/scg_pkg.sv ----
// What this block does
// - a gating bit of one keeps that unit clocked in the selected mode
// - a gating bit of zero stops that unit's clock and disables it
// - accesses to a unit whose clock is off answer with a bus fault
// - gating bits come up zero after reset, all units unclocked in sleep
// - this register applies in sleep; companions cover run and deep sleep
// - sleep settings apply only while automatic clock gating is selected
// - bit 24 is read-write gating for bus controller 0, reset zero
// - bit 3 is read-write gating for the watchdog, reset zero
// - register resets to 0x00000040; bit 6 reads one, other reserved zero
// - register sits at offset 0x110 of the system control space
package scg_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFF = 12'h110;
  localparam logic [ADDR_W-1:0] CFG_OFF        = 12'h1f0;
  localparam logic [ADDR_W-1:0] ACTIVE_OFF     = 12'h1f4;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF   = 12'h200;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFF    = 12'h204;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFF     = 12'h208;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BUS_CTRL0_BIT     = 24;
  localparam int unsigned WATCHDOG_BIT      = 3;
  localparam int unsigned AUTO_GATE_SEL_BIT = 0;
  localparam logic [DATA_W-1:0] SLEEP_GATE_RESET = 32'h0000_0040;
  localparam logic [DATA_W-1:0] SLEEP_GATE_FIXED = 32'h0000_0040;
  localparam logic [1:0]        RESP_OKAY        = 2'h0;
  localparam logic [1:0]        RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // one bit per gated unit; status, clear and enable share this layout
  typedef struct packed {
    logic bus_ctrl0;
    logic watchdog;
  } scg_gate_t;

  localparam scg_gate_t GATE_RESET = 2'h0;

  // gray codes along run -> sleep -> deep sleep
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b11
  } scg_mode_t;

endpackage

// ---- verif/scg_sleep_gate_assertions.sv ----
`timescale 1ns/1ps
module scg_sleep_gate_chk
  import scg_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst_n,
  input wire logic      awvalid,
  input wire logic      awready,
  input wire logic      wvalid,
  input wire logic      wready,
  input wire logic [1:0] bresp,
  input wire logic      bvalid,
  input wire logic      bready,
  input wire logic      arvalid,
  input wire logic      arready,
  input wire logic [1:0] rresp,
  input wire logic      rvalid,
  input wire logic      rready,
  input wire logic      deepsleep_req,
  input wire scg_gate_t run_gate,
  input wire scg_gate_t deepsleep_gate,
  input wire scg_gate_t unit_access,
  input wire scg_gate_t unit_clk_en,
  input wire scg_gate_t unit_fault,
  input wire scg_mode_t mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fault_exact: assert property (1 |=> unit_fault == $past(unit_access & ~unit_clk_en))
    else $error("fault does not match access to unclocked unit");
  a_run_follow: assert property (mode == MODE_RUN |=> unit_clk_en == $past(run_gate))
    else $error("run mode clock enables wrong");
  a_deep_follow: assert property (mode == MODE_DEEP |=> unit_clk_en == $past(deepsleep_gate))
    else $error("deep sleep clock enables wrong");
  a_deep_wins: assert property (deepsleep_req && mode != MODE_RUN |=> mode == MODE_DEEP)
    else $error("deep sleep request not honoured");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rresp))
    else $error("read response dropped");
  a_reset_off: assert property ($rose(rst_n) |-> unit_clk_en == GATE_RESET)
    else $error("units clocked out of reset");
endmodule

bind scg_sleep_gate scg_sleep_gate_chk scg_sleep_gate_chk_i (.clk, .rst_n, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rresp, .rvalid, .rready,
  .deepsleep_req, .run_gate, .deepsleep_gate, .unit_access, .unit_clk_en, .unit_fault, .mode);

// ---- verif/scg_sleep_gate_tb.sv ----
`timescale 1ns/1ps
module scg_sleep_gate_tb
  import scg_pkg::*;
;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, sleep_req = 0, deepsleep_req = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, rs;
  scg_gate_t   run_gate = 0, deepsleep_gate = 0, unit_access = 0, unit_clk_en, unit_fault;
  scg_mode_t   mode;
  int          err_total = 0, compares = 0;

  always #2 clk = ~clk;

  scg_sleep_gate scg_sleep_gate_i (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sleep_req, .deepsleep_req, .run_gate, .deepsleep_gate, .unit_access,
    .unit_clk_en, .unit_fault, .mode, .irq);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // both tasks are entered just after a rising edge and leave just after one
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_on, w_on;
    aw_on = 1;
    w_on = 1;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (aw_on || w_on) begin
      @(posedge clk);
      if (awready) begin aw_on = 0; awvalid <= 0; end
      if (wready) begin w_on = 0; wvalid <= 0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic axr(input logic [11:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // table: write, then read back
  // ----------------------------------------------------------------
  typedef struct { logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] br;
                   logic [31:0] r; logic [1:0] rr; } row_t;
  row_t rows [7] = '{
    '{12'h110, 32'hffff_ffff, 4'hf, RESP_OKAY,   32'h0100_0048, RESP_OKAY},
    '{12'h110, 32'h0000_0000, 4'hf, RESP_OKAY,   32'h0000_0040, RESP_OKAY},
    '{12'h110, 32'h0100_0008, 4'h1, RESP_OKAY,   32'h0000_0048, RESP_OKAY},
    '{12'h114, 32'h0000_0001, 4'hf, RESP_SLVERR, 32'h0000_0000, RESP_SLVERR},
    '{12'h111, 32'h0000_0001, 4'hf, RESP_SLVERR, 32'h0000_0000, RESP_SLVERR},
    '{12'h1f0, 32'h0000_0001, 4'hf, RESP_OKAY,   32'h0000_0001, RESP_OKAY},
    '{12'h208, 32'h0000_0003, 4'hf, RESP_OKAY,   32'h0000_0003, RESP_OKAY}};

  initial begin
    wait_n(20000);
    err_total++;
    end_of_test();
  end

  initial begin
    wait_n(4);
    rst_n <= 1;
    wait_n(3);
    axr(12'h110); chk(rd, SLEEP_GATE_RESET);
    axr(12'h1f4); chk(rd, 32'h0);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, rows[i].s); chk(rs, rows[i].br);
      axr(rows[i].a);
      chk(rs, rows[i].rr);
      chk(rd, rows[i].r);
    end
    // read-modify-write keeps reserved bits and the enabled watchdog
    axr(12'h110);
    axw(12'h110, rd, 4'hf);
    chk(rs, RESP_OKAY);
    // answers held back: they must stand until taken
    araddr <= 12'h110;
    arvalid <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    wait_n(3);
    rready <= 1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 0;
    chk(rdata, 32'h0000_0048);
    awaddr <= 12'h110;
    wdata <= 32'h0000_0048;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 0;
    wvalid <= 0;
    wait_n(3);
    bready <= 1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 0;
    chk(bresp, RESP_OKAY);
    // sleep with watchdog gated on, bus controller gated off
    sleep_req <= 1;
    wait_n(3);
    axr(12'h1f4); chk(rd, 32'h5);
    unit_access <= 2'b01;
    @(posedge clk) unit_access <= 2'b10;
    @(posedge clk) unit_access <= 2'b00;
    @(posedge clk) chk(irq, 1'b1);
    chk(unit_fault, 32'h2);
    axr(12'h200); chk(rd, 32'h2);
    axw(12'h204, 32'h2, 4'h1);
    axr(12'h200); chk(rd, 32'h0);
    chk(irq, 1'b0);
    // a masked event still sets status but leaves irq low
    axw(12'h208, 32'h1, 4'h1);
    unit_access <= 2'b10;
    @(posedge clk) unit_access <= 2'b00;
    wait_n(2);
    chk(irq, 1'b0);
    axr(12'h200); chk(rd, 32'h2);
    // deep sleep overrides sleep
    deepsleep_gate <= 2'b10;
    deepsleep_req <= 1;
    wait_n(3);
    axr(12'h1f4); chk(rd, 32'he);
    // without automatic gating the run settings rule
    // leave deep sleep first; sleep stays requested
    run_gate <= 2'b11;
    deepsleep_req <= 0;
    axw(12'h1f0, 32'h0, 4'h1);
    wait_n(3);
    axr(12'h1f4); chk(rd, 32'h3);
    // reset in mid-run, with run settings cleared first
    run_gate <= 2'b00;
    wait_n(3);
    rst_n <= 0;
    wait_n(4);
    rst_n <= 1;
    wait_n(3);
    axr(12'h110); chk(rd, SLEEP_GATE_RESET);
    axr(12'h200); chk(rd, 32'h0);
    end_of_test();
  end
endmodule
